// ==== efb_errcode.sv ====
`timescale 1ns/1ps
module efb_errcode (
	input  wire efb_pkg::efb_tab_e tab,
	input  wire logic [12:0]       index,
	input  wire logic              outside,
	output logic [63:0]            code
);
	import efb_pkg::*;

	logic [15:0] low;

	always_comb begin
		low = 16'h0;
		if (tab != TAB_NONE) begin
			low[15:3]        = index;
			low[ERR_OUTSIDE] = outside;
			low[ERR_VECTAB]  = (tab == TAB_IDT);
			low[ERR_LOCAL]   = (tab == TAB_LDT);
		end
		// Unrelated or null segment leaves the low word clear
		code = {48'h0, low};
	end

endmodule

// ==== efb_mem_model.sv ====
`timescale 1ns/1ps
module efb_mem_model (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [63:0] mem_addr,
	input  wire logic [63:0] mem_wdata,
	output logic [63:0]      mem_rdata,
	output logic             mem_ack
);
	// Word store keyed by address bits 15:3; every table the bench uses lies below 64 KB
	logic [63:0] store [0:8191];
	logic [63:0] last_reg;
	logic [1:0]  wait_reg;
	int          wr_cnt;
	int          rd_cnt;

	function automatic logic [63:0] peek(input logic [63:0] a);
		return store[a[15:3]];
	endfunction

	function automatic void poke(input logic [63:0] a, input logic [63:0] d);
		store[a[15:3]] = d;
	endfunction

	initial begin
		foreach (store[i])
			store[i] = 64'h0;
	end

	////////////////////////////////////////////////////////////
	// Slow mode holds every access two extra cycles
	assign mem_ack   = mem_req && (!slow || wait_reg == 2'h2);
	// Idle data lines show the inverse of the last value
	assign mem_rdata = (mem_ack && !mem_we) ? store[mem_addr[15:3]] : ~last_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wait_reg <= 2'h0;
			last_reg <= 64'h0;
		end else if (mem_ack) begin
			wait_reg <= 2'h0;
			last_reg <= mem_we ? mem_wdata : mem_rdata;
		end else if (mem_req) begin
			wait_reg <= wait_reg + 2'h1;
		end
	end

	always @(posedge clock) begin
		if (mem_req && mem_ack && mem_we) begin
			store[mem_addr[15:3]] = mem_wdata;
			wr_cnt++;
		end
		if (mem_req && mem_ack && !mem_we)
			rd_cnt++;
	end
endmodule

// ==== efb_pkg.sv ====
package efb_pkg;

	// Register offsets
	localparam logic [7:0]  REG_IDT_BASE   = 8'h00;
	localparam logic [7:0]  REG_GDT_BASE   = 8'h08;
	localparam logic [7:0]  REG_TSS_BASE   = 8'h10;
	localparam logic [7:0]  REG_STATUS     = 8'h18;
	localparam logic [63:0] BASE_RESET     = 64'h0;

	// Gate and descriptor layout
	localparam logic [63:0] GATE_BYTES     = 64'h10;
	localparam logic [63:0] SLOT_BYTES     = 64'h8;
	localparam logic [63:0] ALIGN_MASK     = 64'hffff_ffff_ffff_fff0;
	localparam logic [3:0]  TYPE_INT64     = 4'he;
	localparam logic [3:0]  TYPE_TRAP64    = 4'hf;
	localparam logic [3:0]  TYPE_INT16     = 4'h6;
	localparam logic [3:0]  TYPE_TRAP16    = 4'h7;
	localparam int          CS_LONG_BIT    = 53;
	localparam int          CS_DSIZE_BIT   = 54;

	// Task-state block offsets
	localparam logic [63:0] TSS_RSP0_OFS   = 64'h4;
	localparam logic [63:0] TSS_ALT1_OFS   = 64'h24;

	// Error code bit positions
	localparam int          ERR_OUTSIDE    = 0;
	localparam int          ERR_VECTAB     = 1;
	localparam int          ERR_LOCAL      = 2;

	typedef enum logic [1:0] {SRC_EXC, SRC_PIN, SRC_LINT, SRC_SOFT} efb_src_e;
	typedef enum logic [1:0] {TAB_NONE, TAB_GDT, TAB_LDT, TAB_IDT} efb_tab_e;

	typedef struct packed {
		logic [7:0]  vector;
		efb_src_e    src;
		logic        outside;
		logic        has_err;
		efb_tab_e    err_tab;
		logic [12:0] err_index;
		logic [1:0]  cur_priv;
		logic [15:0] ss;
		logic [63:0] rsp;
		logic [63:0] flags;
		logic [15:0] cs;
		logic [63:0] instruction_pointer_64;
	} efb_entry_s;

	typedef struct packed {
		logic        mode64;
		logic        target64;
		logic [1:0]  priv;
		logic [15:0] ss;
		logic [63:0] rsp;
	} efb_ret_s;

	typedef struct packed {
		logic [63:0] instruction_pointer_64;
		logic [15:0] cs;
		logic [63:0] flags;
		logic [63:0] rsp;
		logic [15:0] ss;
		logic [1:0]  priv;
		logic        ss_desc_load;
	} efb_frame_s;

	function automatic logic efb_canon(input logic [63:0] a);
		return a[63:47] == {17{a[47]}};
	endfunction

endpackage

// ==== efb_top.sv ====
`timescale 1ns/1ps
module efb_top (
	input  wire logic               clock,
	input  wire logic               reset_n,
	input  wire logic [7:0]         reg_addr,
	input  wire logic [63:0]        reg_wdata,
	input  wire logic               reg_write,
	input  wire logic               reg_read,
	output logic [63:0]             reg_rdata,
	input  wire logic               ent_start,
	input  wire efb_pkg::efb_entry_s ent_info,
	input  wire logic               ret_start,
	input  wire efb_pkg::efb_ret_s  ret_info,
	output logic                    mem_req,
	output logic                    mem_we,
	output logic [63:0]             mem_addr,
	output logic [63:0]             mem_wdata,
	input  wire logic [63:0]        mem_rdata,
	input  wire logic               mem_ack,
	output logic                    busy,
	output logic                    done,
	output logic                    fault,
	output logic [63:0]             fault_code,
	output efb_pkg::efb_frame_s     frame
);
	import efb_pkg::*;

	typedef enum logic [2:0] {S_IDLE, S_GLO, S_GHI, S_CSD, S_STK, S_PUSH, S_POP, S_END} efb_state_e;

	efb_state_e  state_reg;
	logic [63:0] idt_base_reg;
	logic [63:0] gdt_base_reg;
	logic [63:0] tss_base_reg;
	logic [63:0] rdata_reg;
	logic        fault_seen_reg;
	efb_entry_s  ent_reg;
	efb_ret_s    ret_reg;
	logic        is_ret_reg;
	logic [63:0] gate_lo_reg;
	logic [63:0] tgt_rip_reg;
	logic [1:0]  new_priv_reg;
	logic        switch_reg;
	logic [2:0]  idx_reg;
	logic [2:0]  cnt_reg;
	logic [63:0] addr_reg;
	logic [63:0] wdata_reg;
	logic        done_reg;
	logic        fault_reg;
	logic [63:0] fault_code_reg;
	efb_frame_s  frame_reg;
	logic [63:0] pop_word [0:4];
	logic [63:0] push_word [0:5];
	logic [63:0] err_word;
	logic [63:0] top_next;
	logic [63:0] gate_rip;
	logic [2:0]  alt_idx;
	logic [3:0]  gate_type;
	logic [1:0]  cs_dpl;
	logic        err_push;
	logic        ss_null;

	efb_errcode u_err (
		.tab     (ent_reg.err_tab),
		.index   (ent_reg.err_index),
		.outside (ent_reg.outside),
		.code    (err_word)
	);

	assign mem_req    = (state_reg != S_IDLE) && (state_reg != S_END);
	assign mem_we     = (state_reg == S_PUSH);
	assign mem_addr   = addr_reg;
	assign mem_wdata  = wdata_reg;
	assign busy       = (state_reg != S_IDLE);
	assign done       = done_reg;
	assign fault      = fault_reg;
	assign fault_code = fault_code_reg;
	assign frame      = frame_reg;
	assign reg_rdata  = rdata_reg;

	assign gate_type = mem_rdata[43:40];
	assign alt_idx   = gate_lo_reg[34:32];
	assign gate_rip  = {mem_rdata[31:0], gate_lo_reg[63:48], gate_lo_reg[15:0]};
	assign cs_dpl    = mem_rdata[46:45];
	assign err_push  = ent_reg.has_err && (ent_reg.src == SRC_EXC);
	assign top_next  = ((state_reg == S_STK) ? mem_rdata : ent_reg.rsp) & ALIGN_MASK;
	assign ss_null   = (pop_word[4][15:2] == 14'h0);

	// Frame image, oldest item first, selectors and error code zero-extended
	always_comb begin
		push_word[0] = {48'h0, ent_reg.ss};
		push_word[1] = ent_reg.rsp;
		push_word[2] = ent_reg.flags;
		push_word[3] = {48'h0, ent_reg.cs};
		push_word[4] = ent_reg.instruction_pointer_64;
		push_word[5] = err_word;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			idt_base_reg <= BASE_RESET;
			gdt_base_reg <= BASE_RESET;
			tss_base_reg <= BASE_RESET;
		end else if (reg_write) begin
			case (reg_addr)
				REG_IDT_BASE: idt_base_reg <= reg_wdata;
				REG_GDT_BASE: gdt_base_reg <= reg_wdata;
				REG_TSS_BASE: tss_base_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_reg <= 64'h0;
		end else if (reg_read) begin
			case (reg_addr)
				REG_IDT_BASE: rdata_reg <= idt_base_reg;
				REG_GDT_BASE: rdata_reg <= gdt_base_reg;
				REG_TSS_BASE: rdata_reg <= tss_base_reg;
				REG_STATUS:   rdata_reg <= {fault_code_reg[55:0], 6'h0, fault_seen_reg, busy};
				default:      rdata_reg <= 64'h0;
			endcase
		end else begin
			rdata_reg <= 64'h0;
		end
	end

	// Sticky fault flag, cleared when the next operation starts
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fault_seen_reg <= 1'b0;
		end else if (fault_reg) begin
			fault_seen_reg <= 1'b1;
		end else if (state_reg == S_IDLE && (ent_start || ret_start)) begin
			fault_seen_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_reg      <= S_IDLE;
			ent_reg        <= '0;
			ret_reg        <= '0;
			is_ret_reg     <= 1'b0;
			gate_lo_reg    <= 64'h0;
			tgt_rip_reg    <= 64'h0;
			new_priv_reg   <= 2'h0;
			switch_reg     <= 1'b0;
			idx_reg        <= 3'h0;
			cnt_reg        <= 3'h0;
			addr_reg       <= 64'h0;
			wdata_reg      <= 64'h0;
			done_reg       <= 1'b0;
			fault_reg      <= 1'b0;
			fault_code_reg <= 64'h0;
			frame_reg      <= '0;
			for (int i = 0; i < 5; i++) begin
				pop_word[i] <= 64'h0;
			end
		end else begin
			done_reg  <= 1'b0;
			fault_reg <= 1'b0;
			case (state_reg)
				S_IDLE: begin
					if (ent_start) begin
						ent_reg    <= ent_info;
						is_ret_reg <= 1'b0;
						addr_reg   <= idt_base_reg + 64'(ent_info.vector) * GATE_BYTES;
						state_reg  <= S_GLO;
					end else if (ret_start) begin
						ret_reg    <= ret_info;
						is_ret_reg <= 1'b1;
						idx_reg    <= 3'h0;
						cnt_reg    <= 3'd3;
						addr_reg   <= ret_info.rsp;
						state_reg  <= S_POP;
					end
				end
				S_GLO: begin
					if (mem_ack) begin
						gate_lo_reg <= mem_rdata;
						if (gate_type == TYPE_INT64 || gate_type == TYPE_TRAP64) begin
							addr_reg  <= addr_reg + SLOT_BYTES;
							state_reg <= S_GHI;
						end else begin
							// 16-bit and any other type fault with zero code
							fault_reg      <= 1'b1;
							fault_code_reg <= 64'h0;
							state_reg      <= S_IDLE;
						end
					end
				end
				S_GHI: begin
					if (mem_ack) begin
						if (!efb_canon(gate_rip)) begin
							fault_reg      <= 1'b1;
							fault_code_reg <= 64'h0;
							state_reg      <= S_IDLE;
						end else begin
							tgt_rip_reg <= gate_rip;
							addr_reg    <= gdt_base_reg + {48'h0, gate_lo_reg[31:19], 3'h0};
							state_reg   <= S_CSD;
						end
					end
				end
				S_CSD: begin
					if (mem_ack) begin
						if (!mem_rdata[CS_LONG_BIT] || mem_rdata[CS_DSIZE_BIT]) begin
							fault_reg      <= 1'b1;
							fault_code_reg <= {56'h0, ent_reg.vector};
							state_reg      <= S_IDLE;
						end else begin
							new_priv_reg <= (cs_dpl < ent_reg.cur_priv) ? cs_dpl : ent_reg.cur_priv;
							if (alt_idx != 3'h0) begin
								switch_reg <= 1'b1;
								addr_reg   <= tss_base_reg + TSS_ALT1_OFS + {58'h0, alt_idx - 3'd1, 3'h0};
								state_reg  <= S_STK;
							end else if (cs_dpl < ent_reg.cur_priv) begin
								switch_reg <= 1'b1;
								addr_reg   <= tss_base_reg + TSS_RSP0_OFS + {59'h0, cs_dpl, 3'h0};
								state_reg  <= S_STK;
							end else begin
								switch_reg <= 1'b0;
								idx_reg    <= 3'h0;
								cnt_reg    <= err_push ? 3'd6 : 3'd5;
								addr_reg   <= top_next - SLOT_BYTES;
								wdata_reg  <= push_word[0];
								state_reg  <= S_PUSH;
							end
						end
					end
				end
				S_STK: begin
					if (mem_ack) begin
						// Only the pointer is fetched; no selector comes from the block
						idx_reg   <= 3'h0;
						cnt_reg   <= err_push ? 3'd6 : 3'd5;
						addr_reg  <= top_next - SLOT_BYTES;
						wdata_reg <= push_word[0];
						state_reg <= S_PUSH;
					end
				end
				S_PUSH: begin
					if (mem_ack) begin
						if (idx_reg == cnt_reg - 3'd1) begin
							frame_reg.instruction_pointer_64          <= tgt_rip_reg;
							frame_reg.cs           <= gate_lo_reg[31:16];
							frame_reg.flags        <= ent_reg.flags;
							frame_reg.rsp          <= addr_reg;
							frame_reg.ss           <= switch_reg ? {14'h0, new_priv_reg} : ent_reg.ss;
							frame_reg.priv         <= new_priv_reg;
							frame_reg.ss_desc_load <= 1'b0;
							done_reg               <= 1'b1;
							state_reg              <= S_IDLE;
						end else begin
							idx_reg   <= idx_reg + 3'd1;
							addr_reg  <= addr_reg - SLOT_BYTES;
							wdata_reg <= push_word[idx_reg + 3'd1];
						end
					end
				end
				S_POP: begin
					if (mem_ack) begin
						pop_word[idx_reg] <= mem_rdata;
						if (idx_reg == 3'd1) begin
							cnt_reg <= (ret_reg.mode64 || mem_rdata[1:0] != ret_reg.priv) ? 3'd5 : 3'd3;
						end
						if (idx_reg >= 3'd2 && idx_reg == cnt_reg - 3'd1) begin
							state_reg <= S_END;
						end else begin
							idx_reg  <= idx_reg + 3'd1;
							addr_reg <= addr_reg + SLOT_BYTES;
						end
					end
				end
				S_END: begin
					state_reg <= S_IDLE;
					if (!efb_canon(pop_word[0]) ||
					    (cnt_reg == 3'd5 && ss_null && (!ret_reg.target64 || pop_word[1][1:0] == 2'd3))) begin
						fault_reg      <= 1'b1;
						fault_code_reg <= 64'h0;
					end else begin
						// The error code slot lies below the saved pointer and is never read
						frame_reg.instruction_pointer_64          <= pop_word[0];
						frame_reg.cs           <= pop_word[1][15:0];
						frame_reg.flags        <= pop_word[2];
						frame_reg.rsp          <= (cnt_reg == 3'd5) ? pop_word[3] : addr_reg + SLOT_BYTES;
						frame_reg.ss           <= (cnt_reg == 3'd5) ? pop_word[4][15:0] : ret_reg.ss;
						frame_reg.priv         <= pop_word[1][1:0];
						frame_reg.ss_desc_load <= (cnt_reg == 3'd5) && !ss_null;
						done_reg               <= 1'b1;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_gate_index: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_IDLE && ent_start) |=> (mem_addr == idt_base_reg + {52'h0, ent_reg.vector, 4'h0}))
		else $error("gate address is not vector times sixteen");

	a_gp_small_gate: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_GLO && mem_ack && (gate_type == TYPE_INT16 || gate_type == TYPE_TRAP16))
		|=> (fault && fault_code == 64'h0 && state_reg == S_IDLE))
		else $error("16-bit gate did not fault with zero code");

	a_gp_canon_rip: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_GHI && mem_ack && (gate_rip[63:47] != {17{gate_rip[47]}})) |=> fault)
		else $error("non-canonical target accepted");

	a_cs_long_check: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_CSD && mem_ack && !(mem_rdata[53] && !mem_rdata[54]))
		|=> (fault && fault_code[7:0] == ent_reg.vector && fault_code[63:8] == 56'h0))
		else $error("bad code segment fault missing or wrong code");

	a_alt_stack_addr: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_CSD && mem_ack && alt_idx != 3'h0 && mem_rdata[53] && !mem_rdata[54])
		|=> (state_reg == S_STK && mem_addr == tss_base_reg + 64'h24 + 64'(alt_idx - 3'd1) * 64'h8))
		else $error("alternate stack pointer fetched from wrong slot");

	a_no_err_pins: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_PUSH && ent_reg.src != SRC_EXC) |-> (cnt_reg == 3'd5))
		else $error("error code pushed for pin or software event");

	a_frame_align: assert property (@(posedge clock) disable iff (!reset_n)
		(done && !is_ret_reg) |-> (frame.rsp[3:0] == ((cnt_reg == 3'd6) ? 4'h0 : 4'h8)))
		else $error("frame not on a 16-byte boundary");

	a_push_ss_first: assert property (@(posedge clock) disable iff (!reset_n)
		($rose(state_reg == S_PUSH)) |-> (mem_we && mem_wdata == {48'h0, ent_reg.ss}))
		else $error("old stack selector not pushed first");

	a_null_ss_switch: assert property (@(posedge clock) disable iff (!reset_n)
		(done && !is_ret_reg && switch_reg) |-> (frame.ss == {14'h0, frame.priv}))
		else $error("switched stack selector not null with new privilege");

	a_ret_pop_count: assert property (@(posedge clock) disable iff (!reset_n)
		(state_reg == S_END && ret_reg.mode64) |-> (cnt_reg == 3'd5))
		else $error("64-bit return did not pop stack pointer and selector");

endmodule

// ==== efb_top_tb_top.sv ====
`timescale 1ns/1ps
module efb_top_tb_top;
	import efb_pkg::*;
	localparam logic [63:0] VECTOR_TABLE_REF_FLAG = 64'h1000;
	localparam logic [63:0] GLOBAL_DESCRIPTOR_TABLE = 64'h2000;
	localparam logic [63:0] TASK_STATE_BLOCK = 64'h3000;
	logic        clock, reset_n, reg_write, reg_read, ent_start, ret_start, slow;
	logic        mem_req, mem_we, mem_ack, busy, done, fault, f;
	logic [7:0]  reg_addr;
	logic [63:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, fault_code;
	logic [63:0] ec [4] = '{64'h0, 64'h29, 64'h2d, 64'h2b};
	efb_entry_s  ent_info;
	efb_ret_s    ret_info;
	efb_frame_s  frame;
	int          error_cnt, checks, w0, r0;

	efb_top DUT (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ent_start(ent_start),
		.ent_info(ent_info), .ret_start(ret_start), .ret_info(ret_info), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .busy(busy), .done(done), .fault(fault), .fault_code(fault_code), .frame(frame));
	efb_mem_model mem_model (.clock(clock), .reset_n(reset_n), .slow(slow), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask

	task end_of_test();
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic wait_end();
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge clock);
			#1;
			if (done === 1'b1 || fault === 1'b1)
				break;
		end
		if (i == 200) begin
			error_cnt++;
			$display("[ERR] %0t no completion", $time);
			end_of_test();
		end
		f = fault;
	endtask

	task automatic wr(input logic [7:0] a, input logic [63:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [63:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask

	task automatic gate(input logic [7:0] v, input logic [63:0] off, input logic [3:0] t, input logic [2:0] alt_stack_index);
		mem_model.poke(VECTOR_TABLE_REF_FLAG + {v, 4'h0}, {off[31:16], 4'h8, t, 5'h00, alt_stack_index, 16'h0008, off[15:0]});
		mem_model.poke(VECTOR_TABLE_REF_FLAG + {v, 4'h0} + 64'h8, {32'h0, off[63:32]});
	endtask

	task automatic cdesc(input logic l, input logic d);
		logic [63:0] c;
		c = 64'h0000_9a00_0000_0000;
		c[53] = l;
		c[54] = d;
		mem_model.poke(GLOBAL_DESCRIPTOR_TABLE + 64'h8, c);
	endtask

	task automatic ent(input logic [7:0] v, input efb_src_e s, input efb_tab_e tab, input logic [1:0] p,
		input logic [63:0] sp);
		w0 = mem_model.wr_cnt;
		@(posedge clock);
		ent_start <= 1'b1;
		ent_info <= '{v, s, 1'b1, 1'b1, tab, 13'h5, p, 16'h2b, sp, 64'h246, 16'h33, 64'h4000_1234};
		@(posedge clock);
		ent_start <= 1'b0;
		wait_end();
	endtask

	task automatic pushes(input logic [63:0] top, input logic [63:0] sp, input int n, input logic [63:0] e);
		chk({63'h0, f}, 64'h0);
		chk(mem_model.peek(top - 64'h8), 64'h2b);
		chk(mem_model.peek(top - 64'h10), sp);
		chk(mem_model.peek(top - 64'h18), 64'h246);
		chk(mem_model.peek(top - 64'h20), 64'h33);
		chk(mem_model.peek(top - 64'h28), 64'h4000_1234);
		if (n == 6)
			chk(mem_model.peek(top - 64'h30), e);
		chk(64'(mem_model.wr_cnt - w0), 64'(n));
		chk(frame.rsp, top - 64'(8 * n));
	endtask

	task automatic ret(input logic m, input logic t, input logic [1:0] p, input logic [15:0] c,
		input logic [15:0] s, input int n, input logic flt);
		mem_model.poke(64'hb000, 64'h5000_0010);
		mem_model.poke(64'hb008, {48'h0, c});
		mem_model.poke(64'hb010, 64'h202);
		mem_model.poke(64'hb018, 64'hc008);
		mem_model.poke(64'hb020, {48'h0, s});
		r0 = mem_model.rd_cnt;
		@(posedge clock);
		ret_start <= 1'b1;
		ret_info <= '{m, t, p, 16'h2b, 64'hb000};
		@(posedge clock);
		ret_start <= 1'b0;
		wait_end();
		chk({63'h0, f}, {63'h0, flt});
		if (!flt) begin
			chk(64'(mem_model.rd_cnt - r0), 64'(n));
			chk(frame.instruction_pointer_64, 64'h5000_0010);
			chk({48'h0, frame.cs}, {48'h0, c});
			chk(frame.flags, 64'h202);
			chk(frame.rsp, n == 5 ? 64'hc008 : 64'hb018);
			chk({48'h0, frame.ss}, n == 5 ? {48'h0, s} : 64'h2b);
			chk({63'h0, frame.ss_desc_load}, {63'h0, n == 5 && s != 16'h0});
		end
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		{reset_n, reg_write, reg_read, ent_start, ret_start, slow} = 6'h0;
		reg_addr = 8'h0;
		reg_wdata = 64'h0;
		ent_info = '0;
		ret_info = '0;
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		wr(REG_IDT_BASE, VECTOR_TABLE_REF_FLAG);
		wr(REG_GDT_BASE, GLOBAL_DESCRIPTOR_TABLE);
		wr(REG_TSS_BASE, TASK_STATE_BLOCK);
		rd(REG_IDT_BASE, VECTOR_TABLE_REF_FLAG);
		rd(REG_TSS_BASE, TASK_STATE_BLOCK);
		rd(8'h20, 64'h0);
		cdesc(1'b1, 1'b0);
		mem_model.poke(TASK_STATE_BLOCK + TSS_ALT1_OFS + 64'h10, 64'ha01c);
		// Pin, local pin and software events, no stack switch
		for (int i = 0; i < 3; i++) begin
			slow <= (i == 1);
			gate(8'h21 + 8'(i), 64'hffff_8000_1234_5678, i[0] ? TYPE_TRAP64 : TYPE_INT64, 3'h0);
			ent(8'h21 + 8'(i), efb_src_e'(i + 1), TAB_GDT, 2'h0, 64'h7ff7 + 64'(i * 64));
			pushes(64'h7ff0 + 64'(i * 64), 64'h7ff7 + 64'(i * 64), 5, 64'h0);
			chk(frame.instruction_pointer_64, 64'hffff_8000_1234_5678);
			chk({48'h0, frame.cs}, 64'h8);
			chk({48'h0, frame.ss}, 64'h2b);
		end
		// Exceptions with error codes across a privilege change
		gate(8'h0d, 64'h0000_7000_0000_0040, TYPE_INT64, 3'h0);
		for (int i = 0; i < 4; i++) begin
			mem_model.poke(TASK_STATE_BLOCK + TSS_RSP0_OFS, 64'h9008 + 64'(i * 128));
			ent(8'h0d, SRC_EXC, efb_tab_e'(i), 2'h3, 64'h5555);
			pushes(64'h9000 + 64'(i * 128), 64'h5555, 6, ec[i]);
			chk({46'h0, frame.ss, frame.priv}, 64'h0);
		end
		// Alternate stack without a privilege change
		gate(8'h02, 64'hffff_ffff_8000_0000, TYPE_INT64, 3'h3);
		ent(8'h02, SRC_PIN, TAB_NONE, 2'h0, 64'h6000);
		pushes(64'ha010, 64'h6000, 5, 64'h0);
		chk({48'h0, frame.ss}, 64'h0);
		// Bad gate type, target pointer and code segment
		for (int i = 0; i < 5; i++) begin
			gate(8'h30, i == 2 ? 64'h0000_8000_0000_0000 : 64'h1000,
				i == 0 ? TYPE_INT16 : (i == 1 ? TYPE_TRAP16 : TYPE_INT64), 3'h0);
			cdesc(i != 3, i == 4);
			ent(8'h30, SRC_EXC, TAB_NONE, 2'h0, 64'h7000);
			chk({63'h0, f}, 64'h1);
			if (i != 2)
				chk(fault_code, i > 2 ? 64'h30 : 64'h0);
		end
		rd(REG_STATUS, 64'h3002);
		cdesc(1'b1, 1'b0);
		ret(1'b1, 1'b1, 2'h0, 16'h8, 16'h10, 5, 1'b0);
		ret(1'b0, 1'b0, 2'h3, 16'h1b, 16'h23, 3, 1'b0);
		ret(1'b0, 1'b0, 2'h3, 16'h8, 16'h10, 5, 1'b0);
		ret(1'b1, 1'b1, 2'h0, 16'h8, 16'h0, 5, 1'b0);
		ret(1'b1, 1'b1, 2'h0, 16'hb, 16'h0, 5, 1'b1);
		ret(1'b1, 1'b0, 2'h0, 16'h8, 16'h0, 5, 1'b1);
		end_of_test();
	end
endmodule
